/* core/card_dma_defs.vh */
// constants for the descriptor dma engine and its buffer rams
// assumes a 32-bit classic wishbone register bus and a 32-bit memory master
// Function
// [RL1] bit 31 gives descriptor to engine; engine clears
// [RL2] bit 30 written as OR of card faults
// [RL3] ring wrap bit returns to list base
// [RL4] linked bit makes word four next pointer
// [RL5] software zeroes second size when linked
// [RL6] first buffer of size zero: data starts next
// [RL7] after last descriptor remaining count is zero
// [RL8] suppress bit withholds done flag for that data
// [RL9] software keeps buffer size a multiple of four
// [RL10] software never programs a zero first size
// [RL11] word three is the full buffer address
// [RL12] linked: next descriptor fetched from word four
// [RL13] software word-aligns every next pointer
// [RL14] descriptor is four words in fixed order
// [RL15] received data lands in rx ram, drained by cpu port or engine
// [RL16] tx ram filled by cpu port or engine
// [RL17] unowned descriptor suspends; poll demand resumes
// [RL18] ownership cleared by writing descriptor word one
// [RL19] fetching starts at the list base register
// [RL20] plain descriptor: next follows at plus sixteen
// [RL21] reserved bits ignored, written back as zero
`ifndef CARD_DMA_DEFS_VH
`define CARD_DMA_DEFS_VH

// register byte offsets
`define ADR_CTRL 10'h080
`define ADR_POLL 10'h084
`define ADR_BASE 10'h088
`define ADR_STAT 10'h08C
`define ADR_COUNT 10'h090
`define ADR_CUR 10'h094
`define ADR_DATA 10'h200

// control register fields
`define CTRL_RUN 0
`define CTRL_TX 1
`define CTRL_SEND 2
`define CTRL_RST 3'h0

// status register fields
`define STAT_TXD 0
`define STAT_RXD 1
`define STAT_UNAV 4
`define STAT_CNT 5

// descriptor control word fields
`define D_OWN 31
`define D_FAULT 30
`define D_RING 5
`define D_LINK 4
`define D_FIRST 3
`define D_LAST 2
`define D_SUPP 1
`define SZ_HI 12
`define SZ_LO 0

// descriptor word indexes and stride
`define W_CTRL 2'h0
`define W_SIZE 2'h1
`define W_BUF 2'h2
`define W_NEXT 2'h3
`define DESC_STRIDE 32'h0000_0010
`define WORD_STEP 32'h0000_0004

`endif

/* core/card_fault_merge.v */
// sticky summary of the seven card fault conditions for one descriptor
// assumes fault inputs are one-cycle or level events synchronous to clk_i
`timescale 1ns/100ps
module card_fault_merge (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // card faults
   input wire end_bit_fault_i,
   input wire reply_timeout_i,
   input wire reply_checksum_fault_i,
   input wire start_bit_fault_i,
   input wire read_data_timeout_i,
   input wire data_checksum_fault_i,
   input wire answer_fault_i,
   // control and result
   input wire clear_i,
   output reg card_fault_summary_ff
);
   wire any_fault;
   assign any_fault = end_bit_fault_i | reply_timeout_i | reply_checksum_fault_i | start_bit_fault_i |
                      read_data_timeout_i | data_checksum_fault_i | answer_fault_i; // RL2

   // a fault in the clearing cycle still counts for the new descriptor
   always @(posedge clk_i) begin
      if (rst_i)
         card_fault_summary_ff <= 1'b0;
      else if (any_fault)
         card_fault_summary_ff <= 1'b1;
      else if (clear_i)
         card_fault_summary_ff <= 1'b0;
   end
endmodule

/* core/card_buffer_ram.v */
// word buffer ram with push and pop ports, used for transmit and receive data
// a push when full or a pop when empty is dropped
`timescale 1ns/100ps
module card_buffer_ram #(
   parameter W = 32,
   parameter AW = 6
) (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // fill side
   input wire push_i,
   input wire [W-1:0] push_data_i,
   // drain side
   input wire pop_i,
   output reg [W-1:0] pop_data_ff,
   output reg pop_valid_ff,
   // flags
   output reg full_ff,
   output reg empty_ff
);
   reg [W-1:0] mem [0:(1<<AW)-1];
   reg [AW-1:0] wr_ptr_ff;
   reg [AW-1:0] rd_ptr_ff;
   reg [AW:0] level_ff;
   wire do_push;
   wire do_pop;
   wire [AW:0] nxt_level;

   assign do_push = push_i & ~full_ff;
   assign do_pop = pop_i & ~empty_ff;
   assign nxt_level = level_ff + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};

   always @(posedge clk_i) begin
      if (do_push)
         mem[wr_ptr_ff] <= push_data_i;
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         level_ff <= {(AW+1){1'b0}};
         pop_data_ff <= {W{1'b0}};
         pop_valid_ff <= 1'b0;
         full_ff <= 1'b0;
         empty_ff <= 1'b1;
      end else begin
         if (do_push)
            wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
         if (do_pop) begin
            rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
            pop_data_ff <= mem[rd_ptr_ff];
         end
         pop_valid_ff <= do_pop;
         level_ff <= nxt_level;
         full_ff <= (nxt_level == (1 << AW));
         empty_ff <= (nxt_level == {(AW+1){1'b0}});
      end
   end
endmodule

/* core/card_host_descriptor_dma.v */
// descriptor-driven dma engine between host memory and the card buffer rams
// assumes host memory answers classic wishbone cycles on the mem_ port and
// software reaches the registers over classic wishbone on the wb_ port
//
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/100ps
`include "card_dma_defs.vh"
module card_host_descriptor_dma #(
   parameter RAM_AW = 6
) (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // register bus slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [9:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // host memory master
   output reg mem_cyc_o,
   output reg mem_stb_o,
   output reg mem_we_o,
   output reg [31:0] mem_adr_o,
   output reg [3:0] mem_sel_o,
   output reg [31:0] mem_dat_o,
   input wire [31:0] mem_dat_i,
   input wire mem_ack_i,
   // card data path, receive side
   input wire rx_push_i,
   input wire [31:0] rx_data_i,
   output wire rx_full_o,
   // card data path, transmit side
   input wire tx_pop_i,
   output wire [31:0] tx_data_o,
   output wire tx_valid_o,
   output wire tx_empty_o,
   // card faults
   input wire end_bit_fault_i,
   input wire reply_timeout_i,
   input wire reply_checksum_fault_i,
   input wire start_bit_fault_i,
   input wire read_data_timeout_i,
   input wire data_checksum_fault_i,
   input wire answer_fault_i
);
   localparam S_IDLE = 3'd0;
   localparam S_FETCH = 3'd1;
   localparam S_CHECK = 3'd2;
   localparam S_MOVE = 3'd3;
   localparam S_RXWAIT = 3'd4;
   localparam S_WBACK = 3'd5;
   localparam S_SUSP = 3'd6;

   reg [2:0] state_ff;
   reg [1:0] idx_ff;
   reg [31:0] ctl_ff;
   reg [12:0] size_ff;
   reg [31:0] bufp_ff;
   reg [31:0] nextp_ff;
   reg [31:0] cur_addr_ff;
   reg [31:0] base_ff;
   reg [31:0] remaining_ff;
   reg [10:0] words_left_ff;
   reg [2:0] ctrl_ff;
   reg txd_ff;
   reg rxd_ff;
   reg unav_ff;
   reg cnt_err_ff;
   reg rd_wait_ff;

   wire card_fault_summary;
   wire rx_empty;
   wire rx_pop_valid;
   wire [31:0] rx_pop_data;
   wire tx_full;

   // next descriptor address: ring wrap wins over the linked pointer
   function [31:0] next_desc;
      input [31:0] ctl;
      input [31:0] cur;
      input [31:0] base;
      input [31:0] nextp;
      begin
         if (ctl[`D_RING])
            next_desc = base; // RL3
         else if (ctl[`D_LINK])
            next_desc = nextp; // RL4 RL12
         else
            next_desc = cur + `DESC_STRIDE; // RL20
      end
   endfunction

   // byte-lane merge for register writes
   function [31:0] lane_merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] sel;
      integer i;
      begin
         lane_merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (sel[i])
               lane_merge[i*8 +: 8] = nw[i*8 +: 8];
      end
   endfunction

   // register bus decode
   wire req;
   wire wr_hit;
   wire rd_data_hit;
   wire poll_hit;
   wire run;
   wire tx_dir;
   wire desc_begin;
   wire wb_done;
   wire cpu_tx_push;
   wire cpu_rx_pop;
   wire dma_tx_push;
   wire dma_rx_pop;
   wire set_txd;
   wire set_rxd;
   wire set_unav;
   wire set_cnt;
   wire last_done;

   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~rd_wait_ff;
   assign wr_hit = req & wb_we_i;
   assign poll_hit = wr_hit & (wb_adr_i == `ADR_POLL);
   assign run = ctrl_ff[`CTRL_RUN];
   assign tx_dir = ctrl_ff[`CTRL_TX];
   // the cpu data port is closed while the run bit is set; if software clears run mid-descriptor, the engine keeps moving and both can hit a ram port
   assign cpu_tx_push = wr_hit & (wb_adr_i == `ADR_DATA) & ctrl_ff[`CTRL_SEND] & ~run; // RL16
   assign rd_data_hit = req & ~wb_we_i & (wb_adr_i == `ADR_DATA) & ~run & ~rx_empty;
   assign cpu_rx_pop = rd_data_hit; // RL15
   assign wb_done = mem_cyc_o & mem_ack_i;
   assign dma_tx_push = (state_ff == S_MOVE) & wb_done & ~mem_we_o; // RL16
   assign dma_rx_pop = (state_ff == S_MOVE) & tx_dir == 1'b0 & ~mem_cyc_o & ~rx_empty &
                       (words_left_ff != 11'd0); // RL15
   assign last_done = (state_ff == S_WBACK) & wb_done & ctl_ff[`D_LAST];
   assign set_txd = last_done & tx_dir & ~ctl_ff[`D_SUPP]; // RL8
   assign set_rxd = last_done & ~tx_dir & ~ctl_ff[`D_SUPP]; // RL8
   assign set_cnt = last_done & (remaining_ff != 32'h0000_0000); // RL7
   assign set_unav = (state_ff == S_CHECK) & ~ctl_ff[`D_OWN]; // RL17
   assign desc_begin = ((state_ff == S_IDLE) & run) | ((state_ff == S_SUSP) & poll_hit) |
                       ((state_ff == S_WBACK) & wb_done & ~ctl_ff[`D_LAST]);

   card_fault_merge u_fault (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .end_bit_fault_i(end_bit_fault_i),
      .reply_timeout_i(reply_timeout_i),
      .reply_checksum_fault_i(reply_checksum_fault_i),
      .start_bit_fault_i(start_bit_fault_i),
      .read_data_timeout_i(read_data_timeout_i),
      .data_checksum_fault_i(data_checksum_fault_i),
      .answer_fault_i(answer_fault_i),
      .clear_i(desc_begin),
      .card_fault_summary_ff(card_fault_summary)
   );

   card_buffer_ram #(.W(32), .AW(RAM_AW)) u_rx_ram (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .push_i(rx_push_i),
      .push_data_i(rx_data_i),
      .pop_i(cpu_rx_pop | dma_rx_pop),
      .pop_data_ff(rx_pop_data),
      .pop_valid_ff(rx_pop_valid),
      .full_ff(rx_full_o),
      .empty_ff(rx_empty)
   );

   card_buffer_ram #(.W(32), .AW(RAM_AW)) u_tx_ram (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .push_i(cpu_tx_push | dma_tx_push),
      .push_data_i(dma_tx_push ? mem_dat_i : wb_dat_i),
      .pop_i(tx_pop_i),
      .pop_data_ff(tx_data_o),
      .pop_valid_ff(tx_valid_o),
      .full_ff(tx_full),
      .empty_ff(tx_empty_o)
   );

   // register bus slave: one wait state, two for a data port read that pops the rx ram (engine stopped, ram not empty)
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         rd_wait_ff <= 1'b0;
      end else begin
         wb_ack_o <= 1'b0;
         rd_wait_ff <= 1'b0;
         if (rd_wait_ff) begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= rx_pop_data;
         end else if (rd_data_hit) begin
            rd_wait_ff <= 1'b1;
         end else if (req) begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= 32'h0000_0000;
            if (!wb_we_i) begin
               case (wb_adr_i)
                  `ADR_CTRL: wb_dat_o <= {29'h0, ctrl_ff};
                  `ADR_BASE: wb_dat_o <= base_ff;
                  `ADR_STAT: begin
                     wb_dat_o[`STAT_TXD] <= txd_ff;
                     wb_dat_o[`STAT_RXD] <= rxd_ff;
                     wb_dat_o[`STAT_UNAV] <= unav_ff;
                     wb_dat_o[`STAT_CNT] <= cnt_err_ff;
                  end
                  `ADR_COUNT: wb_dat_o <= remaining_ff;
                  `ADR_CUR: wb_dat_o <= cur_addr_ff;
                  default: wb_dat_o <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

   // status flags: write one to clear, a hardware set in the same cycle wins
   wire stat_wr;
   assign stat_wr = wr_hit & (wb_adr_i == `ADR_STAT) & wb_sel_i[0];
   always @(posedge clk_i) begin
      if (rst_i) begin
         txd_ff <= 1'b0;
         rxd_ff <= 1'b0;
         unav_ff <= 1'b0;
         cnt_err_ff <= 1'b0;
      end else begin
         txd_ff <= set_txd | (txd_ff & ~(stat_wr & wb_dat_i[`STAT_TXD]));
         rxd_ff <= set_rxd | (rxd_ff & ~(stat_wr & wb_dat_i[`STAT_RXD]));
         unav_ff <= set_unav | (unav_ff & ~(stat_wr & wb_dat_i[`STAT_UNAV]));
         cnt_err_ff <= set_cnt | (cnt_err_ff & ~(stat_wr & wb_dat_i[`STAT_CNT]));
      end
   end

   // descriptor engine
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= S_IDLE;
         idx_ff <= `W_CTRL;
         ctl_ff <= 32'h0000_0000;
         size_ff <= 13'h0000;
         bufp_ff <= 32'h0000_0000;
         nextp_ff <= 32'h0000_0000;
         cur_addr_ff <= 32'h0000_0000;
         base_ff <= 32'h0000_0000;
         remaining_ff <= 32'h0000_0000;
         words_left_ff <= 11'h000;
         ctrl_ff <= `CTRL_RST;
         mem_cyc_o <= 1'b0;
         mem_stb_o <= 1'b0;
         mem_we_o <= 1'b0;
         mem_adr_o <= 32'h0000_0000;
         mem_sel_o <= 4'h0;
         mem_dat_o <= 32'h0000_0000;
      end else begin
         if (wb_done) begin
            mem_cyc_o <= 1'b0;
            mem_stb_o <= 1'b0;
         end
         if (wr_hit && wb_adr_i == `ADR_CTRL && wb_sel_i[0])
            ctrl_ff <= wb_dat_i[2:0];
         if (wr_hit && wb_adr_i == `ADR_COUNT)
            remaining_ff <= lane_merge(remaining_ff, wb_dat_i, wb_sel_i);
         if (wr_hit && wb_adr_i == `ADR_BASE && state_ff == S_IDLE) begin
            base_ff <= lane_merge(base_ff, wb_dat_i, wb_sel_i);
            cur_addr_ff <= lane_merge(base_ff, wb_dat_i, wb_sel_i); // RL19
         end
         case (state_ff)
            S_IDLE: begin
               idx_ff <= `W_CTRL;
               if (run)
                  state_ff <= S_FETCH;
            end
            S_FETCH: begin
               if (!mem_cyc_o) begin
                  mem_cyc_o <= 1'b1;
                  mem_stb_o <= 1'b1;
                  mem_we_o <= 1'b0;
                  mem_sel_o <= 4'hF;
                  mem_adr_o <= cur_addr_ff + {28'h0, idx_ff, 2'b00}; // RL14
               end else if (mem_ack_i) begin
                  case (idx_ff)
                     `W_CTRL: ctl_ff <= mem_dat_i;
                     `W_SIZE: size_ff <= mem_dat_i[`SZ_HI:`SZ_LO];
                     `W_BUF: bufp_ff <= mem_dat_i; // RL11
                     `W_NEXT: nextp_ff <= mem_dat_i; // RL12
                     default: ctl_ff <= ctl_ff;
                  endcase
                  idx_ff <= idx_ff + 2'd1;
                  if (idx_ff == `W_NEXT)
                     state_ff <= S_CHECK;
               end
            end
            S_CHECK: begin
               if (!ctl_ff[`D_OWN])
                  state_ff <= S_SUSP; // RL17
               else if (ctl_ff[`D_FIRST] && size_ff == 13'h0000)
                  state_ff <= S_WBACK; // RL6
               else begin
                  words_left_ff <= size_ff[12:2];
                  state_ff <= S_MOVE;
               end
            end
            S_SUSP: begin
               idx_ff <= `W_CTRL;
               if (poll_hit)
                  state_ff <= S_FETCH; // RL17
            end
            S_MOVE: begin
               if (wb_done) begin
                  bufp_ff <= bufp_ff + `WORD_STEP;
                  words_left_ff <= words_left_ff - 11'd1;
                  if (remaining_ff >= `WORD_STEP)
                     remaining_ff <= remaining_ff - `WORD_STEP;
                  else
                     remaining_ff <= 32'h0000_0000;
               end else if (!mem_cyc_o) begin
                  if (words_left_ff == 11'h000)
                     state_ff <= S_WBACK;
                  else if (tx_dir && !tx_full) begin
                     mem_cyc_o <= 1'b1;
                     mem_stb_o <= 1'b1;
                     mem_we_o <= 1'b0;
                     mem_sel_o <= 4'hF;
                     mem_adr_o <= bufp_ff; // RL11
                  end else if (dma_rx_pop)
                     state_ff <= S_RXWAIT;
               end
            end
            S_RXWAIT: begin
               if (rx_pop_valid) begin
                  mem_cyc_o <= 1'b1;
                  mem_stb_o <= 1'b1;
                  mem_we_o <= 1'b1;
                  mem_sel_o <= 4'hF;
                  mem_adr_o <= bufp_ff; // RL11
                  mem_dat_o <= rx_pop_data;
                  state_ff <= S_MOVE;
               end
            end
            S_WBACK: begin
               if (!mem_cyc_o) begin
                  mem_cyc_o <= 1'b1;
                  mem_stb_o <= 1'b1;
                  mem_we_o <= 1'b1;
                  mem_sel_o <= 4'hF;
                  mem_adr_o <= cur_addr_ff; // RL18
                  mem_dat_o <= {1'b0, card_fault_summary, 24'h000000, ctl_ff[`D_RING:`D_SUPP], 1'b0}; // RL1 RL2 RL21
               end else if (mem_ack_i) begin
                  cur_addr_ff <= next_desc(ctl_ff, cur_addr_ff, base_ff, nextp_ff);
                  idx_ff <= `W_CTRL;
                  if (ctl_ff[`D_LAST]) begin
                     ctrl_ff[`CTRL_RUN] <= 1'b0; // RL7
                     state_ff <= S_IDLE;
                  end else
                     state_ff <= S_FETCH;
               end
            end
            default: state_ff <= S_IDLE;
         endcase
      end
   end
endmodule

/* test/card_dma_properties.sv */
// assertions on register bus, memory master and transmit pop
// assumes the first memory read after a write or reset is descriptor word one
`timescale 1ns/100ps
module card_dma_properties (
   // clock and reset
   input logic clk_i,
   input logic rst_i,
   // register bus
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_ack_o,
   // memory master
   input logic mem_cyc_o,
   input logic mem_we_o,
   input logic [31:0] mem_adr_o,
   input logic [3:0] mem_sel_o,
   input logic [31:0] mem_dat_o,
   input logic [31:0] mem_dat_i,
   input logic mem_ack_i,
   // transmit side
   input logic tx_pop_i,
   input logic tx_empty_o,
   input logic tx_valid_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [3:0] rd_run_ff;
   logic [31:0] desc_adr_ff, desc_ctl_ff;
   wire rd_done = mem_cyc_o && mem_ack_i && !mem_we_o;
   wire wr_done = mem_cyc_o && mem_ack_i && mem_we_o;
   // a refetch after suspend counts past four reads and keeps the entry address
   always @(posedge clk_i) begin
      if (rst_i) begin
         rd_run_ff <= 4'h0;
         desc_adr_ff <= 32'h0;
         desc_ctl_ff <= 32'h0;
      end else if (wr_done)
         rd_run_ff <= 4'h0;
      else if (rd_done) begin
         if (rd_run_ff != 4'hF)
            rd_run_ff <= rd_run_ff + 4'h1;
         if (rd_run_ff == 4'h0)
            desc_adr_ff <= mem_adr_o;
         if (rd_run_ff == 4'h0 || mem_adr_o == desc_adr_ff)
            desc_ctl_ff <= mem_dat_i;
      end
   end
   chk_mem_hold: assert property (mem_cyc_o && !mem_ack_i |=> mem_cyc_o && $stable(mem_adr_o)
      && $stable(mem_we_o) && $stable(mem_dat_o)) else $error("mem request moved");
   chk_mem_release: assert property (mem_cyc_o && mem_ack_i |=> !mem_cyc_o)
      else $error("mem request held");
   chk_mem_lanes: assert property (mem_cyc_o |-> mem_sel_o == 4'hF)
      else $error("mem lanes");
   chk_desc_words: assert property (rd_done && rd_run_ff inside {4'h1, 4'h2, 4'h3} |->
      mem_adr_o == desc_adr_ff + {26'h0, rd_run_ff, 2'h0}) else $error("desc word order");
   chk_own_release: assert property (wr_done && mem_adr_o == desc_adr_ff |-> !mem_dat_o[31])
      else $error("own kept");
   chk_flags_kept: assert property (wr_done && mem_adr_o == desc_adr_ff |->
      mem_dat_o[29:0] == {24'h0, desc_ctl_ff[5:1], 1'b0}) else $error("flags wrong");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   chk_ack_bound: assert property (wb_cyc_i && wb_stb_i && !$past(wb_cyc_i) |-> ##[1:2] wb_ack_o)
      else $error("no ack");
   chk_tx_answer: assert property (tx_pop_i && !tx_empty_o |=> tx_valid_o)
      else $error("tx pop unanswered");
   chk_tx_cause: assert property (tx_valid_o |-> $past(tx_pop_i) && !$past(tx_empty_o))
      else $error("tx word without pop");
   cov_writeback: cover property (wr_done && mem_adr_o == desc_adr_ff);
   cov_tx_word: cover property (tx_valid_o);
   cov_slow_answer: cover property (mem_cyc_o && !mem_ack_i ##1 mem_cyc_o && !mem_ack_i ##1 mem_ack_i);
endmodule
bind card_host_descriptor_dma card_dma_properties chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_cyc_o(mem_cyc_o), .mem_we_o(mem_we_o),
   .mem_adr_o(mem_adr_o), .mem_sel_o(mem_sel_o), .mem_dat_o(mem_dat_o), .mem_dat_i(mem_dat_i),
   .mem_ack_i(mem_ack_i), .tx_pop_i(tx_pop_i), .tx_empty_o(tx_empty_o), .tx_valid_o(tx_valid_o));

/* test/host_mem_model.sv */
// host memory answering the engine's classic wishbone master port
// assumes a 4 KiB window; higher address bits ignored
`timescale 1ns/100ps
module host_mem_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus from the engine
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // wait states before each answer
   input wire logic [3:0] delay_i
);
   logic [31:0] m [0:1023];
   logic [3:0] wait_ff;
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         wait_ff <= 4'h0;
         dat_o <= 32'h0;
      end else if (cyc_i && stb_i && !ack_o) begin
         if (wait_ff == delay_i) begin
            wait_ff <= 4'h0;
            ack_o <= 1'b1;
            dat_o <= m[adr_i[11:2]];
            if (we_i) begin
               m[adr_i[11:2]] <= dat_i;
            end
         end else begin
            wait_ff <= wait_ff + 4'h1;
         end
      end else begin
         ack_o <= 1'b0;
         // released data changes every cycle so a late sample never looks valid
         dat_o <= ~dat_o;
      end
   end
endmodule

/* test/card_host_descriptor_dma_tb_top.sv */
// bench: register bus master, host memory model, card data path
// assumes descriptors are built in the memory model's array
`timescale 1ns/100ps
module card_host_descriptor_dma_tb_top;
   logic clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we = 1'b0, rx_push = 1'b0, tx_pop = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [31:0] wdat = 32'h0, rx_data = 32'h0;
   logic [6:0] flt = 7'h00;
   logic [3:0] mdelay = 4'h0;
   logic [31:0] wb_dat_o, mem_adr_o, mem_dat_o, mem_dat_i, tx_data_o, q;
   logic wb_ack_o, mem_cyc_o, mem_stb_o, mem_we_o, mem_ack_i, rx_full_o, tx_valid_o, tx_empty_o;
   logic [3:0] mem_sel_o;
   int errors = 0, total_checks = 0, cycles = 0;
   always #25 clk_i = ~clk_i;
   card_host_descriptor_dma #(.RAM_AW(6)) dut (.clk_i, .rst_i, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o, .mem_cyc_o, .mem_stb_o, .mem_we_o,
      .mem_adr_o, .mem_sel_o, .mem_dat_o, .mem_dat_i, .mem_ack_i, .rx_push_i(rx_push), .rx_data_i(rx_data),
      .rx_full_o, .tx_pop_i(tx_pop), .tx_data_o, .tx_valid_o, .tx_empty_o, .end_bit_fault_i(flt[0]),
      .reply_timeout_i(flt[1]), .reply_checksum_fault_i(flt[2]), .start_bit_fault_i(flt[3]),
      .read_data_timeout_i(flt[4]), .data_checksum_fault_i(flt[5]), .answer_fault_i(flt[6]));
   host_mem_model mem (.clk_i, .rst_i, .cyc_i(mem_cyc_o), .stb_i(mem_stb_o), .we_i(mem_we_o),
      .adr_i(mem_adr_o), .dat_i(mem_dat_o), .dat_o(mem_dat_i), .ack_o(mem_ack_i), .delay_i(mdelay));
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         $display("unexpected at %0t: timeout", $time);
         give_verdict();
      end
   end
   task automatic check(input logic [31:0] got, exp, input string what);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge clk_i);
      req <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      req <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      check(q, exp, what);
   endtask
   task automatic run_to_end();
      do bus(1'b0, 10'h080, 32'h0); while (q[0] !== 1'b0);
   endtask
   task automatic put_desc(input int a, input logic [31:0] c, s, b, n);
      mem.m[a/4] = c;
      mem.m[a/4+1] = s;
      mem.m[a/4+2] = b;
      mem.m[a/4+3] = n;
   endtask
   task automatic pop_tx();
      @(posedge clk_i);
      tx_pop <= 1'b1;
      @(posedge clk_i);
      tx_pop <= 1'b0;
      @(negedge clk_i);
      check({31'h0, tx_valid_o}, 32'h1, "tx valid");
      q = tx_data_o;
   endtask
   task automatic regs_after_reset();
      rd_chk(10'h08C, 32'h0, "status");
      rd_chk(10'h3FC, 32'h0, "unmapped");
      bus(1'b1, 10'h3FC, 32'hFFFF_FFFF);
      rd_chk(10'h200, 32'h0, "empty rx port");
      bus(1'b1, 10'h088, 32'h100);
      rd_chk(10'h088, 32'h100, "base");
      rd_chk(10'h094, 32'h100, "cur at base");
      rd_chk(10'h084, 32'h0, "poll");
   endtask
   task automatic transmit_chain();
      bus(1'b1, 10'h080, 32'h4);
      bus(1'b1, 10'h200, 32'h5A5A_0001);
      pop_tx();
      check(q, 32'h5A5A_0001, "cpu word");
      put_desc(32'h100, 32'h8000_0008, 32'h8, 32'h400, 32'h300);
      put_desc(32'h110, 32'h8000_1010, 32'h4, 32'h408, 32'h180);
      put_desc(32'h180, 32'h8000_0024, 32'h4, 32'h40C, 32'h300);
      for (int i = 0; i < 4; i++) mem.m[256+i] = 32'hC0DE_0000 + i;
      mdelay <= 4'h3;
      bus(1'b1, 10'h090, 32'h10);
      bus(1'b1, 10'h080, 32'h3);
      run_to_end();
      for (int i = 0; i < 4; i++) begin
         pop_tx();
         check(q, 32'hC0DE_0000 + i, "tx word");
      end
      check(mem.m[64], 32'h0000_0008, "plain wb");
      check(mem.m[68], 32'h0000_0010, "linked wb");
      check(mem.m[96], 32'h0000_0024, "ring wb");
      rd_chk(10'h08C, 32'h1, "tx done");
      rd_chk(10'h094, 32'h100, "ring wrap");
      rd_chk(10'h090, 32'h0, "count");
      bus(1'b1, 10'h08C, 32'h33);
      rd_chk(10'h08C, 32'h0, "cleared");
      mdelay <= 4'h0;
   endtask
   task automatic fault_each();
      for (int i = 0; i < 7; i++) begin
         put_desc(32'h300, 32'h8000_000C, 32'h0, 32'h500, 32'h0);
         bus(1'b1, 10'h090, 32'h4);
         bus(1'b1, 10'h088, 32'h300);
         flt <= 7'h01 << i;
         bus(1'b1, 10'h080, 32'h1);
         run_to_end();
         flt <= 7'h00;
         check(mem.m[192], 32'h4000_000C, "fault");
         rd_chk(10'h08C, 32'h22, "rx status");
         bus(1'b1, 10'h08C, 32'h33);
      end
   endtask
   task automatic receive_suspend();
      put_desc(32'h200, 32'h0000_0008, 32'h0, 32'h500, 32'h0);
      put_desc(32'h210, 32'h8000_0006, 32'h8, 32'h500, 32'h0);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_i);
         rx_push <= 1'b1;
         rx_data <= 32'hBEEF_0000 + i;
      end
      @(posedge clk_i);
      rx_push <= 1'b0;
      check({31'h0, rx_full_o}, 32'h0, "rx full");
      bus(1'b1, 10'h090, 32'h8);
      bus(1'b1, 10'h088, 32'h200);
      bus(1'b1, 10'h080, 32'h1);
      do bus(1'b0, 10'h08C, 32'h0); while (q[4] !== 1'b1);
      rd_chk(10'h094, 32'h200, "suspended");
      mem.m[128] = 32'h8000_0008;
      bus(1'b1, 10'h084, 32'h0);
      run_to_end();
      check(mem.m[320], 32'hBEEF_0000, "rx word0");
      check(mem.m[321], 32'hBEEF_0001, "rx word1");
      check(mem.m[128], 32'h0000_0008, "empty wb");
      check(mem.m[132], 32'h0000_0006, "suppressed wb");
      rd_chk(10'h08C, 32'h10, "withheld");
      rd_chk(10'h200, 32'hBEEF_0002, "cpu drain");
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      regs_after_reset();
      transmit_chain();
      fault_each();
      receive_suspend();
      give_verdict();
   end
endmodule
